// ---- rtl/uart_ccfb_cfg.svh ----
// constants of the control-character, flow-control and break block
`ifndef UART_CCFB_CFG_SVH
`define UART_CCFB_CFG_SVH
// register indices (4-bit port address)
`define A_MODE   4'h0
`define A_CMD    4'h1
`define A_BRKCNT 4'h2
`define A_BRKEV  4'h3
`define A_EVT    4'h4
`define A_HOLD   4'h5
`define A_STAT   4'h6
`define TAB_SEL  3
`define TAB_IX   2:0
// mode register bits
`define M_SUB0 0
`define M_SUB1 1
`define M_CL8  2
`define M_PEN  3
`define M_SL2  4
`define M_TXEN 5
`define M_FRZ  6
`define M_MSG  7
// command bits
`define C_STOP    0
`define C_RESTART 1
`define C_HUNT    2
// event bits
`define E_RX  0
`define E_TX  1
`define E_CCR 2
`define E_CTS 3
`define E_BRK 4
`define EVT_W 5
// table entry fields
`define T_E   15
`define T_R   14
`define T_REA 13
`define T_I   12
`define T_CT  11
`define T_A   8
`define T_CH  7:0
`define FLOW_IX 3'h7
`define ENT_RST 16'h8000
// timing: core clocks per line bit
`define BIT_CYC 5'h10
`endif

// ---- rtl/uart_ccfb_pkg.sv ----
// types of the control-character, flow-control and break block
package uart_ccfb_pkg;
  typedef enum logic [1:0] {SK_CHAR, SK_BREAK, SK_IDLE, SK_MARK} serkind_t;
  typedef enum logic [2:0] {TX_IDLE, TX_CHAR, TX_PRE, TX_FLOW, TX_BREAK, TX_MARK} txst_t;
  typedef struct packed {
    logic        txd;
    logic        busy;
    logic        done;
    logic [12:0] shift;
    logic [3:0]  left;
    logic [4:0]  div;
  } ser_t;
  typedef struct packed {
    logic [7:0]       mode;
    logic [15:0]      brkCount;
    logic [15:0]      brkLeft;
    logic [15:0]      brkEv;
    logic [4:0]       evt;
    logic [7:0]       hold;
    logic [7:0][15:0] tab;
    logic             hunt;
    logic             stopping;
    logic             stopped;
    logic             restartPend;
    logic             ctsSeen;
    txst_t            txSt;
    logic [15:0]      rdData;
    logic [7:0]       rxOut;
    logic             rxStore;
    logic             rxClose;
    logic             bufReady;
    logic             txAbort;
    logic             bdCtsLost;
    logic             autoAddr;
    logic             serStart;
    serkind_t         serKind;
    logic [7:0]       serData;
    logic             serAddr;
  } top_t;
endpackage

// ---- rtl/uart_seq_tx.sv ----
// line serializer for characters, break, preamble and mark bits
`timescale 1ns/1ps
`default_nettype none
`include "uart_ccfb_cfg.svh"
module uart_seq_tx (
  input  wire logic                 core_clk,
  input  wire logic                 rst,
  input  wire logic                 start,
  input  wire uart_ccfb_pkg::serkind_t kind,
  input  wire logic [7:0]           data,
  input  wire logic                 addr,
  input  wire logic                 cl8,
  input  wire logic                 parity_on,
  input  wire logic                 sl2,
  input  wire logic                 addrEn,
  output logic                      txd,
  output logic                      busy,
  output logic                      done
);
  // ************************
  // frame geometry
  // ************************
  // one frame is 9 to 13 bits, so break and preamble share its length
  function automatic logic [3:0] frameLen(input logic c8, input logic p,
                                          input logic s2, input logic a);
    frameLen = 4'h9 + {3'h0, c8} + {3'h0, p} + {3'h0, s2} + {3'h0, a};
  endfunction

  uart_ccfb_pkg::ser_t sReg;
  uart_ccfb_pkg::ser_t sNext;
  logic [12:0]         frame;
  int                  pos;

  always_comb begin
    frame = '1;
    pos = 1;
    frame[0] = 1'b0;
    for (int i = 0; i < 8; i++) begin
      if (i < 7 || cl8) begin
        frame[pos[3:0]] = data[i];
        pos = pos + 1;
      end
    end
    if (parity_on) begin
      // odd parity over the data bits sent
      frame[pos[3:0]] = ~(^(data & {cl8, 7'h7F}));
      pos = pos + 1;
    end
    if (addrEn) begin
      frame[pos[3:0]] = addr;
    end
  end

  // ************************
  // bit sequencing
  // ************************
  always_comb begin
    sNext = sReg;
    sNext.done = 1'b0;
    if (start) begin
      sNext.busy = 1'b1;
      sNext.div = 5'h00;
      sNext.left = frameLen(cl8, parity_on, sl2, addrEn);
      unique case (kind)
        uart_ccfb_pkg::SK_CHAR: begin
          sNext.txd = frame[0];
          sNext.shift = frame >> 1;
        end
        uart_ccfb_pkg::SK_BREAK: begin
          sNext.txd = 1'b0;
          sNext.shift = 13'h0000;
        end
        uart_ccfb_pkg::SK_IDLE: begin
          sNext.txd = 1'b1;
          sNext.shift = 13'h1FFF;
        end
        uart_ccfb_pkg::SK_MARK: begin
          sNext.txd = 1'b1;
          sNext.shift = 13'h1FFF;
          sNext.left = 4'h1;
        end
      endcase
    end else if (sReg.busy) begin
      sNext.div = sReg.div + 5'h01;
      if (sReg.div == `BIT_CYC - 5'h01) begin
        sNext.div = 5'h00;
        if (sReg.left == 4'h1) begin
          // line level is held so back-to-back breaks stay low
          sNext.busy = 1'b0;
          sNext.done = 1'b1;
        end else begin
          sNext.left = sReg.left - 4'h1;
          sNext.txd = sReg.shift[0];
          sNext.shift = sReg.shift >> 1;
        end
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sReg <= '0;
      sReg.txd <= 1'b1;
    end else begin
      sReg <= sNext;
    end
  end

  assign txd = sReg.txd;
  assign busy = sReg.busy;
  assign done = sReg.done;

  AST_BREAK_LOW: assert property (@(posedge core_clk) disable iff (rst)
    start && kind == uart_ccfb_pkg::SK_BREAK |=> !txd [*8])
    else $error("break bit not low");
  AST_MARK_HIGH: assert property (@(posedge core_clk) disable iff (rst)
    start && kind == uart_ccfb_pkg::SK_MARK |=> txd [*8] ##1 busy)
    else $error("mark bit not high");
  AST_PRE_HIGH: assert property (@(posedge core_clk) disable iff (rst)
    start && kind == uart_ccfb_pkg::SK_IDLE |=> (txd && busy) [*8])
    else $error("preamble not high");
endmodule
`default_nettype wire

// ---- rtl/uart_ctrl_char_flow_break.sv ----
// control-character match, flow-control send, break, preamble and hunt
//
// Design decisions made here: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "uart_ccfb_cfg.svh"
module uart_ctrl_char_flow_break (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic [3:0]  regAddr,
  input  wire logic [15:0] regWrData,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic [15:0]      regRdData,
  input  wire logic        rxCharValid,
  input  wire logic [7:0]  rxChar,
  input  wire logic        rxAddrBit,
  input  wire logic        rxFrameErr,
  input  wire logic        rxIdle,
  output logic             rxStore,
  output logic [7:0]       rxCharOut,
  output logic             rxCloseBuf,
  input  wire logic        bufValid,
  input  wire logic [7:0]  bufChar,
  input  wire logic        bufAddrBit,
  input  wire logic        bufPreamble,
  input  wire logic        bufActive,
  output logic             bufReady,
  output logic             txAbort,
  output logic             bdCtsLost,
  output logic             autoAddrMatch,
  input  wire logic        ctsOk,
  output logic             txd
);
  // ************************
  // table scan
  // ************************
  // result is {hit, reject, index}
  function automatic logic [4:0] scanTab(input logic [7:0][15:0] t, input logic [7:0] c);
    logic stop;
    scanTab = 5'h00;
    stop = 1'b0;
    for (int i = 0; i < 8; i++) begin
      if (!stop && t[i][`T_E]) begin
        stop = 1'b1;
      end else if (!stop && t[i][`T_CH] == c) begin
        stop = 1'b1;
        scanTab = {1'b1, t[i][`T_R], i[2:0]};
      end
    end
  endfunction

  uart_ccfb_pkg::top_t r;
  uart_ccfb_pkg::top_t n;
  logic                serBusy;
  logic                serDone;
  logic [4:0]          scan;
  logic                isBrk;
  logic                flowRdy;
  logic [15:0]         flowEnt;

  assign scan = scanTab(r.tab, rxChar);
  assign isBrk = rxCharValid && rxChar == 8'h00 && rxFrameErr;
  assign flowEnt = r.tab[`FLOW_IX];
  // flow use needs empty set, reject clear
  assign flowRdy = r.mode[`M_TXEN] && flowEnt[`T_E] && !flowEnt[`T_R] && flowEnt[`T_REA];

  // ************************
  // next state
  // ************************
  always_comb begin
    n = r;
    n.rdData = 16'h0000;
    n.rxStore = 1'b0;
    n.rxClose = 1'b0;
    n.bufReady = 1'b0;
    n.txAbort = 1'b0;
    n.bdCtsLost = 1'b0;
    n.serStart = 1'b0;
    n.autoAddr = r.mode[`M_SUB1] && r.mode[`M_SUB0];
    if (regWr) begin
      if (regAddr[`TAB_SEL]) begin
        n.tab[regAddr[`TAB_IX]] = regWrData;
      end else begin
        case (regAddr)
          `A_MODE:   n.mode = regWrData[7:0];
          `A_BRKCNT: n.brkCount = regWrData;
          `A_BRKEV:  n.brkEv = regWrData;
          `A_EVT:    n.evt = r.evt & ~regWrData[`EVT_W-1:0];
          `A_CMD: begin
            if (regWrData[`C_STOP]) begin
              n.txAbort = 1'b1;
              n.stopping = 1'b1;
              n.stopped = 1'b1;
              n.restartPend = 1'b0;
              n.brkLeft = r.brkCount;
            end
            if (regWrData[`C_RESTART]) begin
              if (n.stopping) begin
                n.restartPend = 1'b1;
              end else begin
                n.stopped = 1'b0;
              end
            end
            if (regWrData[`C_HUNT]) begin
              n.hunt = 1'b1;
              n.rxClose = 1'b1;
              n.evt[`E_RX] = 1'b1;
            end
          end
          default: ;
        endcase
      end
    end
    if (regRd) begin
      if (regAddr[`TAB_SEL]) begin
        n.rdData = r.tab[regAddr[`TAB_IX]];
      end else begin
        case (regAddr)
          `A_MODE:   n.rdData = {8'h00, r.mode};
          `A_BRKCNT: n.rdData = r.brkCount;
          `A_BRKEV:  n.rdData = r.brkEv;
          `A_EVT:    n.rdData = {11'h000, r.evt};
          `A_HOLD:   n.rdData = {8'h00, r.hold};
          `A_STAT:   n.rdData = {12'h000, r.stopping, r.stopped, serBusy, r.hunt};
          default:   n.rdData = 16'h0000;
        endcase
      end
    end
    // ************************
    // receive side
    // ************************
    if (isBrk) begin
      n.brkEv = r.brkEv + 16'h0001;
      n.evt[`E_BRK] = 1'b1;
      n.rxClose = !r.hunt;
    end else if (rxCharValid && r.hunt) begin
      if (r.mode[`M_SUB0] && rxAddrBit) begin
        n.hunt = 1'b0;
        n.rxStore = 1'b1;
        n.rxOut = rxChar;
      end
    end else if (rxCharValid && r.mode[`M_MSG] && scan[4]) begin
      if (scan[3]) begin
        n.hold = rxChar;
        n.evt[`E_CCR] = 1'b1;
      end else begin
        n.rxStore = 1'b1;
        n.rxOut = rxChar;
        n.rxClose = 1'b1;
        n.evt[`E_RX] = 1'b1;
      end
    end else if (rxCharValid) begin
      n.rxStore = 1'b1;
      n.rxOut = rxChar;
    end
    if (rxIdle && r.hunt && !r.mode[`M_SUB0] && !r.mode[`M_SUB1]) begin
      n.hunt = 1'b0;
    end
    // ************************
    // transmit side
    // ************************
    unique case (r.txSt)
      uart_ccfb_pkg::TX_IDLE: begin
        if (!serBusy) begin
          if (flowRdy) begin
            n.serStart = 1'b1;
            n.serKind = uart_ccfb_pkg::SK_CHAR;
            n.serData = flowEnt[`T_CH];
            n.serAddr = flowEnt[`T_A];
            n.ctsSeen = 1'b0;
            n.txSt = uart_ccfb_pkg::TX_FLOW;
          end else if (r.stopping) begin
            if (r.brkLeft != 16'h0000) begin
              n.serStart = 1'b1;
              n.serKind = uart_ccfb_pkg::SK_BREAK;
              n.txSt = uart_ccfb_pkg::TX_BREAK;
            end else begin
              n.stopping = 1'b0;
              n.stopped = !r.restartPend;
              n.restartPend = 1'b0;
            end
          end else if (r.mode[`M_TXEN] && !r.stopped && !r.mode[`M_FRZ] && bufValid) begin
            n.bufReady = 1'b1;
            n.serStart = 1'b1;
            n.serData = bufChar;
            n.serAddr = bufAddrBit;
            n.serKind = bufPreamble ? uart_ccfb_pkg::SK_IDLE : uart_ccfb_pkg::SK_CHAR;
            n.txSt = bufPreamble ? uart_ccfb_pkg::TX_PRE : uart_ccfb_pkg::TX_CHAR;
          end
        end
      end
      uart_ccfb_pkg::TX_CHAR: begin
        if (serDone) begin
          n.txSt = uart_ccfb_pkg::TX_IDLE;
        end
      end
      uart_ccfb_pkg::TX_PRE: begin
        if (serDone) begin
          n.serStart = 1'b1;
          n.serKind = uart_ccfb_pkg::SK_CHAR;
          n.txSt = uart_ccfb_pkg::TX_CHAR;
        end
      end
      uart_ccfb_pkg::TX_FLOW: begin
        if (!ctsOk && !r.ctsSeen) begin
          n.ctsSeen = 1'b1;
          n.tab[`FLOW_IX][`T_CT] = 1'b1;
          n.evt[`E_CTS] = 1'b1;
          n.bdCtsLost = bufActive;
        end
        if (serDone) begin
          n.tab[`FLOW_IX][`T_REA] = 1'b0;
          if (flowEnt[`T_I]) begin
            n.evt[`E_TX] = 1'b1;
          end
          n.txSt = uart_ccfb_pkg::TX_IDLE;
        end
      end
      uart_ccfb_pkg::TX_BREAK: begin
        if (serDone) begin
          n.brkLeft = r.brkLeft - 16'h0001;
          n.serStart = 1'b1;
          if (r.brkLeft == 16'h0001) begin
            n.serKind = uart_ccfb_pkg::SK_MARK;
            n.txSt = uart_ccfb_pkg::TX_MARK;
          end else begin
            n.serKind = uart_ccfb_pkg::SK_BREAK;
          end
        end
      end
      uart_ccfb_pkg::TX_MARK: begin
        if (serDone) begin
          // idle, or resume on earlier restart
          n.stopping = 1'b0;
          n.stopped = !r.restartPend;
          n.restartPend = 1'b0;
          n.txSt = uart_ccfb_pkg::TX_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      r <= '0;
      r.tab <= {8{`ENT_RST}};
      r.txSt <= uart_ccfb_pkg::TX_IDLE;
      r.serKind <= uart_ccfb_pkg::SK_CHAR;
    end else begin
      r <= n;
    end
  end

  uart_seq_tx u_ser (
    .core_clk (core_clk),
    .rst      (rst),
    .start    (r.serStart),
    .kind     (r.serKind),
    .data     (r.serData),
    .addr     (r.serAddr),
    .cl8      (r.mode[`M_CL8]),
    .parity_on      (r.mode[`M_PEN]),
    .sl2      (r.mode[`M_SL2]),
    .addrEn   (r.mode[`M_SUB0]),
    .txd      (txd),
    .busy     (serBusy),
    .done     (serDone)
  );

  assign regRdData = r.rdData;
  assign rxStore = r.rxStore;
  assign rxCharOut = r.rxOut;
  assign rxCloseBuf = r.rxClose;
  assign bufReady = r.bufReady;
  assign txAbort = r.txAbort;
  assign bdCtsLost = r.bdCtsLost;
  assign autoAddrMatch = r.autoAddr;

  AST_BREAK_COUNT: assert property (@(posedge core_clk) disable iff (rst)
    isBrk |=> r.brkEv == $past(r.brkEv) + 16'h0001 && r.evt[`E_BRK] && !rxStore)
    else $error("break not counted");
  AST_REJECT: assert property (@(posedge core_clk) disable iff (rst)
    rxCharValid && !isBrk && !r.hunt && r.mode[`M_MSG] && scan[4] && scan[3]
    |=> r.hold == $past(rxChar) && r.evt[`E_CCR] && !rxStore && !rxCloseBuf)
    else $error("reject not held");
  AST_STORE_CLOSE: assert property (@(posedge core_clk) disable iff (rst)
    rxCharValid && !isBrk && !r.hunt && r.mode[`M_MSG] && scan[4] && !scan[3]
    |=> rxStore && rxCloseBuf && rxCharOut == $past(rxChar) && r.evt[`E_RX])
    else $error("store match not closed");
  AST_HUNT_QUIET: assert property (@(posedge core_clk) disable iff (rst)
    rxCharValid && r.hunt && !rxAddrBit |=> !rxStore)
    else $error("hunt passed data");
  AST_FLOW_FIRST: assert property (@(posedge core_clk) disable iff (rst)
    r.txSt == uart_ccfb_pkg::TX_IDLE && !serBusy && flowRdy
    |=> !bufReady && r.txSt == uart_ccfb_pkg::TX_FLOW)
    else $error("buffer beat flow char");
  AST_FLOW_DONE: assert property (@(posedge core_clk) disable iff (rst)
    r.txSt == uart_ccfb_pkg::TX_FLOW && serDone
    |=> !r.tab[`FLOW_IX][`T_REA] && (r.evt[`E_TX] || !$past(flowEnt[`T_I])))
    else $error("ready not cleared");
  AST_FLOW_HOLD: assert property (@(posedge core_clk) disable iff (rst)
    r.txSt == uart_ccfb_pkg::TX_FLOW && !serDone && !regWr
    |=> r.tab[`FLOW_IX][`T_REA])
    else $error("ready dropped early");
  AST_CTS_LOST: assert property (@(posedge core_clk) disable iff (rst)
    r.txSt == uart_ccfb_pkg::TX_FLOW && !ctsOk && !r.ctsSeen
    |=> r.tab[`FLOW_IX][`T_CT] && r.evt[`E_CTS] && bdCtsLost == $past(bufActive))
    else $error("cts loss not flagged");
endmodule
`default_nettype wire

// ---- dv/uart_line_peer.sv ----
// remote serial station: line decoder and clear-to-send source
`timescale 1ns/1ps
`default_nettype none
module uart_line_peer (
  input  wire logic core_clk,
  input  wire logic txd,
  input  wire logic dropCts,
  output logic      ctsOk,
  output logic [7:0] lastByte,
  output int        frames,
  output int        lowRun
);
  int run = 0;
  assign ctsOk = !dropCts;
  // ************************************
  // decoder: 8 data bits, lsb first, mid-bit samples
  // ************************************
  initial begin
    frames = 0;
    lastByte = 8'h00;
    forever begin
      @(negedge txd);
      repeat (8) @(posedge core_clk);
      for (int i = 0; i < 8; i++) begin
        repeat (16) @(posedge core_clk);
        lastByte[i] = txd;
      end
      frames++;
      // a break series decodes as one zero byte, then waits for the mark
      while (txd !== 1'b1) @(posedge core_clk);
    end
  end
  always @(posedge core_clk) begin
    run <= txd ? 0 : run + 1;
    if (txd && run != 0) lowRun <= run;
  end
endmodule
`default_nettype wire

// ---- dv/testbench.sv ----
// self-checking bench of the control-character, flow and break block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        core_clk, rst, regWr, regRd, rxCharValid, rxAddrBit, rxFrameErr, rxIdle;
  logic        bufValid, bufAddrBit, bufPreamble, bufActive, dropCts, ctsOk, txd;
  logic        rxStore, rxCloseBuf, bufReady, txAbort, bdCtsLost, autoAddrMatch;
  logic [3:0]  regAddr;
  logic [15:0] regWrData, regRdData;
  logic [7:0]  rxChar, rxCharOut, bufChar, lastByte;
  int          frames, lowRun, n;
  int          bad_count = 0;
  int          num_checks = 0;
  uart_ctrl_char_flow_break uart_ctrl_char_flow_break_i (.core_clk, .rst, .regAddr,
    .regWrData, .regWr, .regRd, .regRdData, .rxCharValid, .rxChar, .rxAddrBit, .rxFrameErr,
    .rxIdle, .rxStore, .rxCharOut, .rxCloseBuf, .bufValid, .bufChar, .bufAddrBit,
    .bufPreamble, .bufActive, .bufReady, .txAbort, .bdCtsLost, .autoAddrMatch, .ctsOk, .txd);
  uart_line_peer uart_line_peer_i (.core_clk, .txd, .dropCts, .ctsOk, .lastByte, .frames,
    .lowRun);
  // ************************************
  // access tasks
  // ************************************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge core_clk);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    @(posedge core_clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge core_clk);
    regRd <= 1'b0;
    #1 chk(regRdData, exp);
  endtask
  // f is {address bit, framing error}; result is {store, close, char}
  task automatic rxc(input logic [7:0] c, input logic [1:0] f, input logic [15:0] exp);
    @(posedge core_clk);
    rxCharValid <= 1'b1;
    rxChar <= c;
    {rxAddrBit, rxFrameErr} <= f;
    @(posedge core_clk);
    rxCharValid <= 1'b0;
    #1 chk({6'h00, rxStore, rxCloseBuf, rxCharOut}, exp);
  endtask
  task automatic idle;
    @(posedge core_clk);
    rxIdle <= 1'b1;
    @(posedge core_clk);
    rxIdle <= 1'b0;
  endtask
  task automatic waitFrame(input int k);
    n = 0;
    while (frames < k && n < 3000) begin
      @(posedge core_clk);
      n++;
    end
    if (n >= 3000) bad_count++;
    // decoder counts before the stop bits end; let the frame finish
    repeat (40) @(posedge core_clk);
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  // the whole run needs under two thousand cycles
  initial begin
    #(100 * 20000);
    bad_count++;
    end_of_test();
  end
  // ************************************
  // tests
  // ************************************
  initial begin
    rst = 1'b1;
    {regWr, regRd, rxCharValid, rxAddrBit, rxFrameErr, rxIdle, dropCts} = '0;
    {bufValid, bufAddrBit, bufPreamble, bufActive, regAddr, regWrData, rxChar, bufChar} = '0;
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    rd(4'hF, 16'h8000);
    rd(4'h7, 16'h0000);
    $display("test registers done");
    wr(4'h0, 16'h0084);
    wr(4'h8, 16'h000D);
    wr(4'h9, 16'h4011);
    wr(4'hA, 16'h4013);
    wr(4'hB, 16'h8000);
    wr(4'hC, 16'h0041);
    rxc(8'h0D, 2'b00, 16'h030D);
    rxc(8'h11, 2'b00, 16'h000D);
    rd(4'h5, 16'h0011);
    rxc(8'h13, 2'b00, 16'h000D);
    rd(4'h5, 16'h0013);
    rd(4'h4, 16'h0005);
    rxc(8'h41, 2'b00, 16'h0241);
    rxc(8'h00, 2'b01, 16'h0141);
    rd(4'h3, 16'h0001);
    wr(4'h0, 16'h0004);
    rxc(8'h0D, 2'b00, 16'h020D);
    $display("test receive done");
    wr(4'h4, 16'h001F);
    wr(4'h1, 16'h0004);
    rd(4'h6, 16'h0001);
    rxc(8'h0D, 2'b00, 16'h000D);
    rxc(8'h00, 2'b01, 16'h000D);
    rd(4'h3, 16'h0002);
    idle();
    rd(4'h6, 16'h0000);
    rd(4'h4, 16'h0011);
    wr(4'h0, 16'h0001);
    wr(4'h1, 16'h0004);
    idle();
    rd(4'h6, 16'h0001);
    rxc(8'h22, 2'b10, 16'h0222);
    rd(4'h6, 16'h0000);
    wr(4'h0, 16'h0003);
    repeat (2) @(posedge core_clk);
    #1 chk(autoAddrMatch, 1'b1);
    $display("test hunt done");
    wr(4'h4, 16'h001F);
    wr(4'h0, 16'h00A4);
    wr(4'hF, 16'hB013);
    repeat (40) @(posedge core_clk);
    rd(4'hF, 16'hB013);
    waitFrame(1);
    chk(lastByte, 8'h13);
    rd(4'hF, 16'h9013);
    rd(4'h4, 16'h0002);
    wr(4'h0, 16'h00E4);
    wr(4'hF, 16'hA017);
    waitFrame(2);
    chk(lastByte, 8'h17);
    wr(4'h0, 16'h00A4);
    wr(4'h4, 16'h001F);
    wr(4'hF, 16'hB011);
    repeat (40) @(posedge core_clk);
    dropCts <= 1'b1;
    bufActive <= 1'b1;
    @(posedge core_clk);
    #1 chk(bdCtsLost, 1'b1);
    repeat (2) @(posedge core_clk);
    dropCts <= 1'b0;
    bufActive <= 1'b0;
    waitFrame(3);
    rd(4'hF, 16'h9811);
    rd(4'h4, 16'h000A);
    $display("test flow done");
    wr(4'h2, 16'h0002);
    wr(4'h1, 16'h0001);
    #1 chk(txAbort, 1'b1);
    n = 0;
    while (txd !== 1'b0 && n < 2000) begin
      @(posedge core_clk);
      n++;
    end
    while (txd !== 1'b1 && n < 2000) begin
      @(posedge core_clk);
      n++;
    end
    repeat (20) @(posedge core_clk);
    // two ten-bit breaks; the gap between them may stay low
    chk(lowRun >= 320 && lowRun <= 340, 1'b1);
    chk(txd, 1'b1);
    rd(4'h6, 16'h0004);
    $display("test break done");
    @(posedge core_clk);
    bufValid <= 1'b1;
    bufChar <= 8'h5A;
    bufPreamble <= 1'b1;
    n = 0;
    repeat (20) begin
      @(posedge core_clk);
      #1 n += bufReady;
    end
    chk(n, 0);
    wr(4'h1, 16'h0002);
    n = 0;
    while (bufReady !== 1'b1 && n < 100) begin
      @(posedge core_clk);
      #1 n++;
    end
    chk(bufReady, 1'b1);
    bufValid <= 1'b0;
    bufPreamble <= 1'b0;
    n = 0;
    while (txd !== 1'b0 && n < 1000) begin
      @(posedge core_clk);
      n++;
    end
    chk(n >= 150 && n <= 200, 1'b1);
    waitFrame(5);
    chk(lastByte, 8'h5A);
    $display("test preamble done");
    wr(4'h8, 16'h8000);
    wr(4'hF, 16'h0000);
    rxc(8'h0D, 2'b00, 16'h020D);
    repeat (40) @(posedge core_clk);
    chk({15'h0000, txd}, 16'h0001);
    rd(4'hF, 16'h0000);
    $display("test disable done");
    end_of_test();
  end
endmodule
`default_nettype wire
